// *** logic/rcs_slave.sv ***
// Serial register control slave, device side
`timescale 1ns/1ps
`default_nettype none

module rcs_slave #(
  parameter int BOOT_CYCLES = rcs_pkg::BOOT_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic port_select_n,
  input wire logic port_serial_clock,
  input wire logic port_serial_in,
  output logic port_serial_out,
  output logic port_serial_out_oe_n,
  output logic out_launch_edge_sel,
  output logic out_drive_strength_sel,
  output logic out_pulldown_en,
  output logic boot_busy,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic [30:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  localparam int BW = (BOOT_CYCLES > 1) ? $clog2(BOOT_CYCLES) : 1;
  localparam logic [BW-1:0] BOOT_LAST = BW'(BOOT_CYCLES - 1);

  if (BOOT_CYCLES < 2 || BOOT_CYCLES > 65536) begin : g_bad_boot
    $error("BOOT_CYCLES out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic sck_m;
    logic sck_s;
    logic sck_p;
    logic ss_m;
    logic ss_s;
    logic mosi_m;
    logic mosi_s;
    rcs_pkg::rcs_phase_t st;
    logic [4:0] cnt;
    logic rw;
    logic [30:0] addr;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [31:0] rdbuf;
    logic rd_pend;
    logic rd_take;
    logic [30:0] raddr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic loc_edge;
    logic loc_drv;
    logic loc_pd;
    logic so;
    logic so_oe_n;
    logic [BW-1:0] boot_cnt;
    logic boot_busy;
  } rcs_state_t;

  rcs_state_t q;
  rcs_state_t d;

  // Local registers answer from here; the rest comes from the core map
  function automatic logic [31:0] read_mux(input logic [30:0] a, input logic [31:0] ext,
                                           input logic edge_sel, input logic drv,
                                           input logic pd);
    logic [31:0] v;
    v = '0;
    if (a == rcs_pkg::OFF_LAUNCH_EDGE) begin
      v[rcs_pkg::LAUNCH_EDGE_BIT] = edge_sel;
    end else if (a == rcs_pkg::OFF_PAD_CFG) begin
      v[rcs_pkg::DRIVE_STR_BIT] = drv;
      v[rcs_pkg::PULLDOWN_BIT] = pd;
    end else begin
      v = ext;
    end
    return v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic rise;
  logic fall;
  logic [31:0] word;

  always_comb begin
    d = q;
    d.wr_stb = 1'b0;
    d.rd_stb = 1'b0;
    // Pins cross into sys_clk through two flops; the clock also keeps a third for edge detection
    d.sck_m = port_serial_clock;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.ss_m = port_select_n;
    d.ss_s = q.ss_m;
    d.mosi_m = port_serial_in;
    d.mosi_s = q.mosi_m;
    rise = q.sck_s & ~q.sck_p;
    fall = ~q.sck_s & q.sck_p;
    word = {q.rx[30:0], q.mosi_s};

    // Boot counter restarts on any reset
    if (q.boot_busy) begin
      d.boot_cnt = q.boot_cnt + 1'b1;
      if (q.boot_cnt == BOOT_LAST) begin
        d.boot_busy = 1'b0; // [R1]
      end
    end

    // Core answers in the cycle after the strobe; take it at that cycle's end
    d.rd_take = q.rd_pend;
    if (q.rd_pend) begin
      d.rd_pend = 1'b0;
    end
    if (q.rd_take) begin
      d.rdbuf = read_mux(q.raddr, reg_rdata, q.loc_edge, q.loc_drv, q.loc_pd);
    end

    if (q.ss_s) begin
      // Frame over: partial word dropped, output released
      d.st = rcs_pkg::RCS_IDLE; // [R15] [R17]
      d.so = 1'b0;
      d.so_oe_n = 1'b1; // [R10]
    end else begin
      unique case (q.st)
        rcs_pkg::RCS_IDLE: begin
          d.st = rcs_pkg::RCS_CMD; // [R15]
          d.cnt = '0;
        end
        rcs_pkg::RCS_CMD: begin
          if (rise) begin
            d.rx = word; // [R16]
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == rcs_pkg::LAST_BIT) begin
              d.rw = word[31]; // [R12]
              d.addr = word[30:0]; // [R11]
              d.st = rcs_pkg::RCS_PAD;
              if (word[31]) begin
                // Padding phase leaves time to fetch the first word
                d.raddr = word[30:0];
                d.rd_stb = 1'b1;
                d.rd_pend = 1'b1;
              end
            end
          end
        end
        rcs_pkg::RCS_PAD: begin
          if (rise) begin
            d.cnt = q.cnt + 1'b1; // [R12]
            if (q.cnt == rcs_pkg::LAST_BIT) begin
              d.st = rcs_pkg::RCS_DATA;
              if (q.rw) begin
                d.tx = q.rdbuf;
                d.raddr = q.addr + 1'b1;
                d.rd_stb = 1'b1;
                d.rd_pend = 1'b1;
              end
            end
          end
        end
        rcs_pkg::RCS_DATA: begin
          if (rise) begin
            d.cnt = q.cnt + 1'b1; // [R14]
            if (!q.rw) begin
              d.rx = word; // [R8]
            end
            // Read frames never sample the input past the address [R9]
            if (q.rw && q.loc_edge) begin
              d.so = q.tx[31]; // [R6]
              d.tx = {q.tx[30:0], 1'b0};
              d.so_oe_n = 1'b0; // [R10]
            end
            if (q.cnt == rcs_pkg::LAST_BIT) begin
              d.addr = q.addr + 1'b1; // [R13]
              if (q.rw) begin
                // Next word was prefetched during the current one
                d.tx = q.rdbuf;
                d.raddr = q.addr + 31'h2;
                d.rd_stb = 1'b1;
                d.rd_pend = 1'b1;
              end else if (q.addr == rcs_pkg::OFF_LAUNCH_EDGE) begin
                // Whole word only; writes during boot are the host's risk [R2] [R17]
                d.loc_edge = word[rcs_pkg::LAUNCH_EDGE_BIT];
              end else if (q.addr == rcs_pkg::OFF_PAD_CFG) begin
                d.loc_drv = word[rcs_pkg::DRIVE_STR_BIT]; // [R7]
                d.loc_pd = word[rcs_pkg::PULLDOWN_BIT];
              end else begin
                d.raddr = q.addr;
                d.wdata = word;
                d.wr_stb = 1'b1;
              end
            end
          end
          if (fall && q.rw && !q.loc_edge) begin
            d.so = q.tx[31]; // [R6]
            d.tx = {q.tx[30:0], 1'b0};
            d.so_oe_n = 1'b0; // [R10]
          end
        end
      endcase
    end

    // Software reset restores configuration and reruns boot
    if (sw_reset) begin
      d.loc_edge = rcs_pkg::LAUNCH_EDGE_RST;
      d.loc_drv = rcs_pkg::DRIVE_STR_RST;
      d.loc_pd = rcs_pkg::PULLDOWN_RST;
      d.boot_cnt = '0;
      d.boot_busy = 1'b1; // [R1]
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Nothing here waits on the core system clock enable [R3]
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.sck_m <= 1'b0;
      q.ss_m <= 1'b1;
      q.ss_s <= 1'b1;
      q.st <= rcs_pkg::RCS_IDLE;
      q.loc_edge <= rcs_pkg::LAUNCH_EDGE_RST;
      q.loc_drv <= rcs_pkg::DRIVE_STR_RST; // [R7]
      q.loc_pd <= rcs_pkg::PULLDOWN_RST;
      q.so_oe_n <= 1'b1;
      q.boot_busy <= 1'b1; // [R1]
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign port_serial_out = q.so; // [R5]
  assign port_serial_out_oe_n = q.so_oe_n;
  assign out_launch_edge_sel = q.loc_edge;
  assign out_drive_strength_sel = q.loc_drv;
  assign out_pulldown_en = q.loc_pd;
  assign boot_busy = q.boot_busy;
  assign reg_wr_stb = q.wr_stb;
  assign reg_rd_stb = q.rd_stb;
  assign reg_addr = q.raddr;
  assign reg_wdata = q.wdata;

endmodule

`default_nettype wire

// *** shared/rcs_pkg.sv ***
// Constants and types for the serial register control slave
// Function
// [R1] Boot sequence runs after power-on, hardware or software reset.
// [R2] Host withholds register writes until the boot sequence is finished.
// [R3] Register access works with or without the core system clock running.
// [R4] Host observes extra limits at slow system clock or high addresses.
// [R5] Port has serial out, serial in, serial clock and active-low select.
// [R6] Output bit launched on falling clock edge if select bit 0, rising if 1.
// [R7] Drive strength bit (default 8 mA) and pull-down enable (default off).
// [R8] On writes the host drives serial input for the whole transfer.
// [R9] On reads serial input is ignored once the address is received.
// [R10] Output driven only while sending read data; otherwise high impedance.
// [R11] Addresses are 31 bits and data words are 32 bits.
// [R12] Each frame holds a read/write bit and a 32-bit padding phase.
// [R13] Continuous mode increments address after each word while selected.
// [R14] Each further word in continuous mode takes exactly 32 clocks.
// [R15] Select low is asserted; frame starts on fall, ends on rise.
// [R16] Order: rw, address, padding, data; MSB first; host samples opposite edge.
// [R17] Select rising mid-word discards the partial word; no partial write.
package rcs_pkg;

  // ----------------------------------------
  // Field sizes
  // ----------------------------------------
  localparam int ADDR_W = 31;
  localparam int DATA_W = 32;
  localparam int PAD_BITS = 32;
  localparam logic [4:0] LAST_BIT = 5'h1f;

  // ----------------------------------------
  // Local configuration registers
  // ----------------------------------------
  localparam logic [30:0] OFF_LAUNCH_EDGE = 31'h0000_0090;
  localparam logic [30:0] OFF_PAD_CFG = 31'h0000_1004;
  localparam int LAUNCH_EDGE_BIT = 0;
  localparam int DRIVE_STR_BIT = 8;
  localparam int PULLDOWN_BIT = 7;
  localparam logic LAUNCH_EDGE_RST = 1'b0;
  localparam logic DRIVE_STR_RST = 1'b1;
  localparam logic PULLDOWN_RST = 1'b0;

  // ----------------------------------------
  // Boot and frame state
  // ----------------------------------------
  localparam int BOOT_CYCLES_DEF = 256;

  typedef enum logic [1:0] {
    RCS_IDLE,
    RCS_CMD,
    RCS_PAD,
    RCS_DATA
  } rcs_phase_t;

endpackage

// *** verification/rcs_slave_properties.sv ***
// Port checker for the serial register control slave
`timescale 1ns/1ps
`default_nettype none
module rcs_slave_properties #(
  parameter int BOOT_CYCLES = rcs_pkg::BOOT_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic port_select_n,
  input wire logic port_serial_clock,
  input wire logic port_serial_out,
  input wire logic port_serial_out_oe_n,
  input wire logic out_launch_edge_sel,
  input wire logic out_drive_strength_sel,
  input wire logic out_pulldown_en,
  input wire logic boot_busy,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb
);
  // ----
  // Boot length, one edge of slack either way
  // ----
  int cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sw_reset) begin
      cnt_q <= 0;
    end else if (boot_busy) begin
      cnt_q <= cnt_q + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rst_vals_a: assert property (disable iff (1'b0)
    !rst_n |=> port_serial_out_oe_n && boot_busy && !reg_wr_stb && !out_launch_edge_sel
    && out_drive_strength_sel && !out_pulldown_en) else $error("reset values");
  sw_cfg_a: assert property (sw_reset |=> boot_busy && !out_launch_edge_sel
    && out_drive_strength_sel && !out_pulldown_en) else $error("sw reset values");
  boot_len_a: assert property ($fell(boot_busy)
    |-> cnt_q inside {[BOOT_CYCLES - 1:BOOT_CYCLES + 1]}) else $error("boot length");
  idle_hiz_a: assert property (port_select_n [*8]
    |-> port_serial_out_oe_n) else $error("driven while deselected");
  park_low_a: assert property (port_serial_out_oe_n
    |-> !port_serial_out) else $error("output not parked");
  launch_edge_a: assert property (
    (!port_serial_out_oe_n && $stable(port_serial_clock)) [*6] |-> $stable(port_serial_out))
    else $error("output moved off edge");
  wr_frame_a: assert property (reg_wr_stb
    |-> !port_select_n && !reg_rd_stb) else $error("write outside frame");
  rd_frame_a: assert property (reg_rd_stb
    |-> !port_select_n ##1 !reg_rd_stb) else $error("read outside frame");
  cover property (reg_wr_stb);
  cover property (reg_rd_stb);
  cover property ($fell(boot_busy));
endmodule
bind rcs_slave rcs_slave_properties #(.BOOT_CYCLES(BOOT_CYCLES)) rcs_slave_properties_inst (
  .sys_clk, .rst_n, .sw_reset, .port_select_n, .port_serial_clock, .port_serial_out,
  .port_serial_out_oe_n, .out_launch_edge_sel, .out_drive_strength_sel, .out_pulldown_en,
  .boot_busy, .reg_wr_stb, .reg_rd_stb);
`default_nettype wire

// *** verification/rcs_host.sv ***
// Host model: frames out, read data in
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
  output logic port_select_n,
  output logic port_serial_clock,
  output logic port_serial_in,
  input wire logic port_serial_out,
  input wire logic port_serial_out_oe_n,
  input wire logic out_launch_edge_sel,
  input wire logic out_pulldown_en
);
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  logic [31:0] r = 32'h0;
  // Floating pin reads the inverse of the last bit, or low with the pull-down on
  wire pin = !port_serial_out_oe_n ? port_serial_out : !out_pulldown_en && !r[0];
  initial begin
    port_select_n = 1'b1;
    port_serial_clock = 1'b0;
    port_serial_in = 1'b0;
  end
  task automatic xfer(input logic rw, input logic [30:0] a, input int n, input int cut);
    logic [63:0] h;
    logic [31:0] w;
    h = {rw, a, 32'h0};
    w = 32'h0;
    port_select_n <= 1'b0;
    #100;
    for (int i = 0; i < 64 + 32 * n && i != cut; i++) begin
      if (i >= 64 && i % 32 == 0 && !rw) w = wq.pop_front();
      port_serial_in <= i < 64 ? h[63 - i] : rw ? !port_serial_in : w[31 - i % 32];
      #62.5 port_serial_clock <= 1'b1;
      if (!out_launch_edge_sel) r = {r[30:0], pin};
      #62.5 port_serial_clock <= 1'b0;
      if (out_launch_edge_sel) r = {r[30:0], pin};
      if (rw && i >= 64 && i % 32 == 31) rq.push_back(r);
    end
    #100 port_select_n <= 1'b1;
    port_serial_in <= !port_serial_in;
    #200;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the serial register control slave
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sw_reset = 1'b0;
  logic [31:0] reg_rdata = 32'h0;
  logic port_select_n, port_serial_clock, port_serial_in, port_serial_out;
  logic port_serial_out_oe_n, out_launch_edge_sel, out_drive_strength_sel, out_pulldown_en;
  logic boot_busy, reg_wr_stb, reg_rd_stb;
  logic [30:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] mem [64];
  logic [31:0] em [64];
  logic [62:0] ew[$];
  int seed = 85;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  always #5 sys_clk = !sys_clk;
  rcs_slave #(.BOOT_CYCLES(4)) rcs_slave_inst (.sys_clk, .rst_n, .sw_reset, .port_select_n,
    .port_serial_clock, .port_serial_in, .port_serial_out, .port_serial_out_oe_n,
    .out_launch_edge_sel, .out_drive_strength_sel, .out_pulldown_en, .boot_busy,
    .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wdata, .reg_rdata);
  rcs_host rcs_host_inst (.port_select_n, .port_serial_clock, .port_serial_in,
    .port_serial_out, .port_serial_out_oe_n, .out_launch_edge_sel, .out_pulldown_en);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // Core map stand-in and write log
  // ----
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (reg_rd_stb) reg_rdata <= mem[reg_addr[5:0]];
    if (reg_wr_stb) begin
      mem[reg_addr[5:0]] <= reg_wdata;
      if (ew.size() == 0) chk("extra write", 32'h0, 32'h1);
      else begin
        chk("wr addr", ew[0][62:32], reg_addr);
        chk("wr data", ew[0][31:0], reg_wdata);
        void'(ew.pop_front());
      end
    end
    if (cyc == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic wr(input logic [30:0] a, input int n, input int cut);
    logic [31:0] d;
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      rcs_host_inst.wq.push_back(d);
      if (cut < 0) em[a + k] = d;
      if (cut < 0) ew.push_back({a + 31'(k), d});
    end
    rcs_host_inst.xfer(1'b0, a, n, cut);
  endtask
  task automatic rd(input logic [30:0] a, input int n);
    rcs_host_inst.xfer(1'b1, a, n, -1);
    for (int k = 0; k < n; k++) chk("rd data", em[a + k], rcs_host_inst.rq.pop_front());
  endtask
  task automatic cfg(input logic e, input logic d, input logic p);
    chk("edge", 32'(e), 32'(out_launch_edge_sel));
    chk("drive", 32'(d), 32'(out_drive_strength_sel));
    chk("pulldown", 32'(p), 32'(out_pulldown_en));
  endtask
  task automatic boot();
    for (int k = 0; k < 50 && boot_busy !== 1'b0; k++) @(posedge sys_clk);
    #1 chk("boot", 32'h0, 32'(boot_busy));
  endtask
  initial begin
    for (int k = 0; k < 64; k++) begin
      mem[k] = $random(seed);
      em[k] = mem[k];
    end
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    cfg(1'b0, 1'b1, 1'b0);
    boot();
    $display("test reset finished");
    wr(31'h5, 3, -1);
    rd(31'h5, 3);
    wr(31'h9, 1, 80);
    rd(31'h8, 2);
    $display("test core finished");
    rcs_host_inst.wq.push_back(32'h1);
    rcs_host_inst.xfer(1'b0, 31'h90, 1, -1);
    rcs_host_inst.wq.push_back(32'h80);
    rcs_host_inst.xfer(1'b0, 31'h1004, 1, -1);
    cfg(1'b1, 1'b0, 1'b1);
    rcs_host_inst.xfer(1'b1, 31'h90, 1, -1);
    chk("edge reg", 32'h1, rcs_host_inst.rq.pop_front() & 32'h1);
    rd(31'h5, 3);
    chk("writes left", 32'h0, 32'(ew.size()));
    $display("test config finished");
    @(posedge sys_clk) sw_reset <= 1'b1;
    @(posedge sys_clk) sw_reset <= 1'b0;
    #1 cfg(1'b0, 1'b1, 1'b0);
    chk("reboot", 32'h1, 32'(boot_busy));
    boot();
    rd(31'h6, 1);
    $display("test soft reset finished");
    complete_run();
  end
endmodule
`default_nettype wire
